/* spimsp_pkg.sv */
// Constants shared by the serial peripheral port: register map, fields, reset values and clock divisors.
// ****************************************************************
// What this block does
// - With select_pin_ignore low, the SS pin level decides master or slave role.
// - With select_pin_ignore high, master_select alone decides; SS is left to plain use.
// - With serial_port_on low the port is off and drives none of its pins.
// - With serial_port_on high the port takes over SCK, MOSI and MISO, and SS while select_pin_ignore is low.
// - bit_order low shifts most significant bit first, high least significant first.
// - master_select low means slave, high means master.
// - clock_polarity sets the idle level of SCK; both ends must agree.
// - clock_phase low samples on the first SCK edge, high on the second.
// - Slave with ignore low and phase low drives its first bit once SS falls.
// - With clock_phase high each bit is driven on the edge before sampling.
// - Master SCK divides the system clock by 4, 16, 64 or 128 per rate_select.
// - A finished byte sets transfer_done_flag, which also requests an interrupt.
// - Writing data during a transfer sets write_collision_flag; the byte shifting stays intact.
// - A byte finishing while transfer_done_flag is set raises receive_overrun_flag.
// - SS contradicting master role sets mode_fault_flag, drops to slave, requests interrupt.
// - The four flags are set by hardware only and cleared by writing one.
// - Status bits 3 to 0 read as zero and ignore writes.
// - Control, status and data registers reset to zero.
// - A slave with no loaded byte sends 0x00.
// - A mode fault clears serial_port_on and master_select.
// - A slave has a byte after counting 8 SCK clocks; data register then holds it unless transfer_done_flag was still set.
// - With select_pin_ignore high no mode fault is raised.
package spimsp_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STAT      = 8'h04;
    localparam logic [7:0] ADDR_DATA      = 8'h08;
    localparam int         BIT_SSIGN      = 7;
    localparam int         BIT_PORT_ON    = 6;
    localparam int         BIT_ORDER      = 5;
    localparam int         BIT_MASTER     = 4;
    localparam int         BIT_POL        = 3;
    localparam int         BIT_PHASE      = 2;
    localparam int         BIT_RATE_HI    = 1;
    localparam int         BIT_RATE_LO    = 0;
    localparam int         BIT_DONE       = 7;
    localparam int         BIT_COLL       = 6;
    localparam int         BIT_OVER       = 5;
    localparam int         BIT_FAULT      = 4;
    localparam logic [7:0] RST_CTRL       = 8'h00;
    localparam logic [7:0] RST_DATA       = 8'h00;
    localparam logic [7:0] IDLE_TX_BYTE   = 8'h00;
    localparam logic [3:0] LAST_EDGE      = 4'hf;

    // ****************************************************************
    // Clock divisors, as system clocks per SCK period
    // ****************************************************************
    localparam int         DIV_RATE0      = 4;
    localparam int         DIV_RATE1      = 16;
    localparam int         DIV_RATE2      = 64;
    localparam int         DIV_RATE3      = 128;

    // ****************************************************************
    // Transfer states
    // ****************************************************************
    typedef enum logic [1:0] {
        SPIMSP_IDLE = 2'b01,
        SPIMSP_RUN  = 2'b10
    } spimsp_mode_t;

endpackage

/* spimsp_top.sv */
// Serial peripheral port, master or slave, with a classic Wishbone register slave.
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spimsp_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_o,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_o,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    input  wire logic        ss_n_i,
    output logic             irq_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]           ctrl;
        logic                 done;
        logic                 coll;
        logic                 over;
        logic                 fault;
        logic [7:0]           rxbuf;
        logic [7:0]           shreg;
        logic                 rxbit;
        logic [3:0]           ecnt;
        spimsp_pkg::spimsp_mode_t mode;
        logic [6:0]           div;
        logic                 sck;
        logic                 ack;
        logic [31:0]          rdata;
        logic [2:0]           ss_s;
        logic [2:0]           sck_s;
        logic [2:0]           mosi_s;
        logic [2:0]           miso_s;
        logic                 ss_f;
        logic                 sck_f;
        logic                 mosi_f;
        logic                 miso_f;
        logic                 sck_prev;
    } spimsp_state_t;

    spimsp_state_t st_q;
    spimsp_state_t st_d;
    logic          edge_c;
    logic          finish_c;
    logic          wr_c;
    logic          master_act;
    logic          slave_sel;
    logic          port_on;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [6:0] half_period(input logic [1:0] rate);
        logic [6:0] h;
        h = 7'h00;
        case (rate)
            2'b00: h = 7'(spimsp_pkg::DIV_RATE0 / 2);
            2'b01: h = 7'(spimsp_pkg::DIV_RATE1 / 2);
            2'b10: h = 7'(spimsp_pkg::DIV_RATE2 / 2);
            default: h = 7'(spimsp_pkg::DIV_RATE3 / 2);
        endcase
        return h;
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb_first);
        return lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    function automatic logic [2:0] sync3(input logic [2:0] s, input logic pin);
        return {s[1:0], pin};
    endfunction

    // ****************************************************************
    // Role decoding
    // ****************************************************************
    assign port_on    = st_q.ctrl[spimsp_pkg::BIT_PORT_ON];
    assign master_act = port_on && st_q.ctrl[spimsp_pkg::BIT_MASTER];
    assign slave_sel  = port_on && !st_q.ctrl[spimsp_pkg::BIT_MASTER] &&
                        (st_q.ctrl[spimsp_pkg::BIT_SSIGN] || !st_q.ss_f);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic       samp;
        logic       rx_in;
        logic       clr_w;
        logic [7:0] sh;
        st_d     = st_q;
        edge_c   = 1'b0;
        finish_c = 1'b0;
        samp     = 1'b0;
        rx_in    = master_act ? st_q.miso_f : st_q.mosi_f;
        sh       = st_q.shreg;
        wr_c     = wb_cyc_i && wb_stb_i && wb_we_i && st_q.ack && wb_sel_i[0];
        clr_w    = wr_c && (wb_adr_i == spimsp_pkg::ADDR_STAT);

        // Pin synchronisers: a level counts once the second and third stages agree.
        st_d.ss_s   = sync3(st_q.ss_s, ss_n_i);
        st_d.sck_s  = sync3(st_q.sck_s, sck_i);
        st_d.mosi_s = sync3(st_q.mosi_s, mosi_i);
        st_d.miso_s = sync3(st_q.miso_s, miso_i);
        if (st_q.ss_s[1] == st_q.ss_s[2]) begin
            st_d.ss_f = st_q.ss_s[2];
        end
        if (st_q.sck_s[1] == st_q.sck_s[2]) begin
            st_d.sck_f = st_q.sck_s[2];
        end
        if (st_q.mosi_s[1] == st_q.mosi_s[2]) begin
            st_d.mosi_f = st_q.mosi_s[2];
        end
        if (st_q.miso_s[1] == st_q.miso_s[2]) begin
            st_d.miso_f = st_q.miso_s[2];
        end
        st_d.sck_prev = st_q.sck_f;

        // Bus slave: ack one cycle after the request, dropped the cycle after.
        st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
        if (st_d.ack) begin
            case (wb_adr_i)
                spimsp_pkg::ADDR_CTRL: st_d.rdata = {24'h000000, st_q.ctrl};
                spimsp_pkg::ADDR_STAT: st_d.rdata = {24'h000000, st_q.done, st_q.coll, st_q.over,
                                                     st_q.fault, 4'h0};
                spimsp_pkg::ADDR_DATA: st_d.rdata = {24'h000000, st_q.rxbuf};
                default: st_d.rdata = 32'h00000000;
            endcase
        end

        // Flags clear on a written one; a set in the same cycle wins below.
        if (clr_w) begin
            st_d.done  = st_q.done && !wb_dat_i[spimsp_pkg::BIT_DONE];
            st_d.coll  = st_q.coll && !wb_dat_i[spimsp_pkg::BIT_COLL];
            st_d.over  = st_q.over && !wb_dat_i[spimsp_pkg::BIT_OVER];
            st_d.fault = st_q.fault && !wb_dat_i[spimsp_pkg::BIT_FAULT];
        end
        if (wr_c && (wb_adr_i == spimsp_pkg::ADDR_CTRL)) begin
            st_d.ctrl = wb_dat_i[7:0];
        end

        // Data writes: start a master byte, preload a slave byte, or collide.
        if (wr_c && (wb_adr_i == spimsp_pkg::ADDR_DATA)) begin
            if (st_q.mode == spimsp_pkg::SPIMSP_RUN) begin
                st_d.coll = 1'b1;
            end else begin
                sh = wb_dat_i[7:0];
                if (master_act) begin
                    st_d.mode = spimsp_pkg::SPIMSP_RUN;
                    st_d.div  = 7'h00;
                    st_d.ecnt = 4'h0;
                end
            end
        end

        // Edge source: own divider as master, synchronised SCK as slave.
        if (master_act && st_q.mode == spimsp_pkg::SPIMSP_RUN) begin
            if (st_q.div == half_period(st_q.ctrl[spimsp_pkg::BIT_RATE_HI:spimsp_pkg::BIT_RATE_LO]) - 7'h01) begin
                st_d.div = 7'h00;
                st_d.sck = ~st_q.sck;
                edge_c   = 1'b1;
            end else begin
                st_d.div = st_q.div + 7'h01;
            end
        end else begin
            st_d.sck = st_q.ctrl[spimsp_pkg::BIT_POL];
        end
        if (slave_sel && (st_q.sck_f != st_q.sck_prev)) begin
            edge_c    = 1'b1;
            st_d.mode = spimsp_pkg::SPIMSP_RUN;
        end

        // Shift engine: sample on one edge parity, shift on the other.
        if (edge_c) begin
            samp = (st_q.ecnt[0] == st_q.ctrl[spimsp_pkg::BIT_PHASE]);
            if (samp) begin
                st_d.rxbit = rx_in;
            end else if (st_q.ecnt != 4'h0) begin
                sh = shift_in(sh, st_q.rxbit, st_q.ctrl[spimsp_pkg::BIT_ORDER]);
            end
            if (st_q.ecnt == spimsp_pkg::LAST_EDGE) begin
                if (samp) begin
                    sh = shift_in(sh, rx_in, st_q.ctrl[spimsp_pkg::BIT_ORDER]);
                end
                finish_c  = 1'b1;
                st_d.ecnt = 4'h0;
                st_d.mode = spimsp_pkg::SPIMSP_IDLE;
                if (st_q.done) begin
                    st_d.over = 1'b1;
                end else begin
                    st_d.rxbuf = sh;
                end
                st_d.done = 1'b1;
                sh = spimsp_pkg::IDLE_TX_BYTE;
            end else begin
                st_d.ecnt = st_q.ecnt + 4'h1;
            end
        end

        // A deselected or disabled slave abandons any partial byte.
        if (!master_act && !slave_sel) begin
            st_d.ecnt = 4'h0;
            st_d.mode = spimsp_pkg::SPIMSP_IDLE;
        end
        st_d.shreg = sh;

        // Mode fault: SS pulled low while configured as master.
        if (master_act && !st_q.ctrl[spimsp_pkg::BIT_SSIGN] && !st_q.ss_f) begin
            st_d.fault = 1'b1;
            st_d.ctrl[spimsp_pkg::BIT_PORT_ON] = 1'b0;
            st_d.ctrl[spimsp_pkg::BIT_MASTER]  = 1'b0;
            st_d.mode = spimsp_pkg::SPIMSP_IDLE;
            st_d.ecnt = 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q       <= '0;
            st_q.ctrl  <= spimsp_pkg::RST_CTRL;
            st_q.rxbuf <= spimsp_pkg::RST_DATA;
            st_q.shreg <= spimsp_pkg::RST_DATA;
            st_q.mode  <= spimsp_pkg::SPIMSP_IDLE;
            st_q.ss_s  <= 3'h7;
            st_q.ss_f  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic out_bit;
    assign out_bit   = st_q.ctrl[spimsp_pkg::BIT_ORDER] ? st_q.shreg[0] : st_q.shreg[7];
    assign wb_ack_o  = st_q.ack;
    assign wb_dat_o  = st_q.rdata;
    assign sck_o     = st_q.sck;
    assign sck_oe_o  = master_act && st_q.mode == spimsp_pkg::SPIMSP_RUN;
    assign mosi_o    = out_bit;
    assign mosi_oe_o = sck_oe_o;
    assign miso_o    = out_bit;
    assign miso_oe_o = slave_sel;
    assign irq_o     = st_q.done || (st_q.fault && !st_q.ctrl[spimsp_pkg::BIT_SSIGN]);

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_OFF_NO_DRIVE: assert property (!port_on |-> !sck_oe_o && !mosi_oe_o && !miso_oe_o)
        else $error("Pins driven while port is off.");
    AST_FAULT_DROPS_ROLE: assert property ($rose(st_q.fault) |-> !st_q.ctrl[6] && !st_q.ctrl[4] && irq_o)
        else $error("Mode fault did not clear enable and master.");
    AST_FAULT_CAUSE: assert property ($rose(st_q.fault) |-> $past(!st_q.ctrl[7] && !st_q.ss_f))
        else $error("Mode fault without pin cause.");
    AST_RESERVED_ZERO: assert property (wb_ack_o && wb_adr_i == spimsp_pkg::ADDR_STAT |-> wb_dat_o[3:0] == 4'h0)
        else $error("Reserved status bits not zero.");
    AST_DONE_STICKY: assert property (st_q.done && !(wr_c && wb_adr_i == spimsp_pkg::ADDR_STAT && wb_dat_i[7])
        |=> st_q.done)
        else $error("Done flag lost without a clear.");
    AST_COLLIDE: assert property (wr_c && wb_adr_i == spimsp_pkg::ADDR_DATA && st_q.mode == spimsp_pkg::SPIMSP_RUN
        |=> st_q.coll)
        else $error("Collision not flagged.");
    AST_OVERRUN: assert property (finish_c && st_q.done |=> st_q.over && $stable(st_q.rxbuf))
        else $error("Overrun not flagged.");
    AST_DONE_ON_FINISH: assert property (finish_c |=> st_q.done && irq_o)
        else $error("Finished byte did not set done.");
    AST_FAST_DIV: assert property (sck_oe_o && st_q.ctrl[1:0] == 2'b00 && $changed(st_q.sck)
        |=> $stable(st_q.sck))
        else $error("Fastest SCK half period is not two clocks.");
    AST_IDLE_LEVEL: assert property (st_q.mode == spimsp_pkg::SPIMSP_IDLE && $past(st_q.mode == spimsp_pkg::SPIMSP_IDLE)
        && $stable(st_q.ctrl) |-> sck_o == st_q.ctrl[3])
        else $error("SCK not at idle level.");

    COV_MASTER_BYTE: cover property (master_act && finish_c);
    COV_SLAVE_BYTE: cover property (slave_sel && finish_c);
    COV_FAULT: cover property ($rose(st_q.fault));
    COV_COLLIDE: cover property ($rose(st_q.coll));

endmodule
`default_nettype wire

/* spimsp_top_fix_note_unused.sv */
// Intentionally empty.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* spimsp_far_dev.sv */
// Far-side slave device that answers the port when it runs as master.
`timescale 1ns/1ps
`default_nettype none
module spimsp_far_dev (
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       en_i,
    input  wire logic       clock_polarity_i,
    input  wire logic       clock_phase_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic      [7:0] rx_o
);
    logic [7:0] sr = 8'h00;
    logic [7:0] rx = 8'h00;
    logic       cur;
    int         n  = 0;

    assign cur    = lsb_i ? sr[0] : sr[7];
    // A released line shows the inverse of its last bit, never a held value.
    assign miso_o = en_i ? cur : ~cur;
    assign rx_o   = rx;

    always @(posedge en_i) begin
        sr = tx_i;
        n  = 0;
    end

    // Samples on the edge picked by phase and polarity and moves on at the other edge.
    always @(sck_i) begin
        if (en_i) begin
            if ((sck_i != clock_polarity_i) ^ clock_phase_i) begin
                rx = lsb_i ? {mosi_i, rx[7:1]} : {rx[6:0], mosi_i};
            end else if (!clock_phase_i || n != 0) begin
                sr = lsb_i ? {1'b0, sr[7:1]} : {sr[6:0], 1'b0};
            end
            n = n + 1;
        end
    end
endmodule
`default_nettype wire

/* tb_spimsp_top.sv */
// Self-checking bench for the serial peripheral port.
`timescale 1ns/1ps
`default_nettype none
module tb_spimsp_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        sck_t = 1'b0, mosi_t = 1'b0, ss_t = 1'b1;
    logic        far_en = 1'b0, clock_polarity = 1'b0, clock_phase = 1'b0, lsb = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00, far_tx = 8'h00, far_rx, q;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, far_miso;
    wire         sck_w  = sck_oe ? sck_o : sck_t;
    wire         mosi_w = mosi_oe ? mosi_o : mosi_t;
    wire         miso_w = miso_oe ? miso_o : far_miso;
    int          miscompares = 0, tests_run = 0, cycles = 0;
    int          divs[4] = '{spimsp_pkg::DIV_RATE0, spimsp_pkg::DIV_RATE1,
                             spimsp_pkg::DIV_RATE2, spimsp_pkg::DIV_RATE3};

    always #5 clk_i = ~clk_i;

    spimsp_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe),
        .ss_n_i(ss_t), .irq_o(irq));

    spimsp_far_dev far (.sck_i(sck_w), .mosi_i(mosi_w), .en_i(far_en), .clock_polarity_i(clock_polarity),
        .clock_phase_i(clock_phase), .lsb_i(lsb), .tx_i(far_tx), .miso_o(far_miso), .rx_o(far_rx));

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // ****************************************************************
    // Bus and link helpers
    // ****************************************************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        chk(8'(n), 8'h02, "ack delay");
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        wb(1'b0, a, 8'h00);
        chk(q, exp, what);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (sck_oe !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        while (sck_oe !== 1'b0 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        chk(8'(n < 3000), 8'h01, "transfer end");
    endtask

    task automatic mxfer(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] ftx);
        time t;
        clock_polarity <= ctl[3];
        clock_phase <= ctl[2];
        lsb <= ctl[5];
        sck_t <= ctl[3];
        far_tx <= ftx;
        wb(1'b1, 8'h00, ctl);
        wt(2);
        chk(sck_o, ctl[3], "idle clock");
        far_en <= 1'b1;
        wb(1'b1, 8'h08, tx);
        @(sck_o);
        t = $time;
        @(sck_o);
        chk(8'(($time - t) / 10), 8'(divs[ctl[1:0]] / 2), "half period");
        wait_done();
        chk(irq, 1'b1, "irq");
        chk(far_rx, tx, "far rx");
        wb(1'b1, 8'h04, 8'h0f);
        rd(8'h04, 8'h80, "status");
        rd(8'h08, ftx, "data");
        wb(1'b1, 8'h04, 8'h80);
        rd(8'h04, 8'h00, "status");
        far_en <= 1'b0;
    endtask

    task automatic fm_byte(input logic [7:0] tx, output logic [7:0] rx);
        ss_t <= 1'b0;
        wt(16);
        chk(miso_oe, 1'b1, "slave out on");
        for (int i = 7; i >= 0; i--) begin
            mosi_t <= tx[i];
            wt(16);
            sck_t <= 1'b1;
            rx[i] = miso_w;
            wt(16);
            sck_t <= 1'b0;
        end
        wt(16);
        ss_t <= 1'b1;
        wt(8);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd(8'h00, 8'h00, "control");
        rd(8'h04, 8'h00, "status");
        rd(8'h08, 8'h00, "data");
        rd(8'h0c, 8'h00, "unmapped");
        chk({sck_oe, mosi_oe, miso_oe}, 8'h00, "pins off");
        $display("reset test done");
    endtask

    task automatic t_master();
        for (int r = 0; r < 4; r++) begin
            mxfer(8'hd0 | 8'(r), 8'ha5 + 8'(r), r == 0 ? 8'h00 : 8'h3c);
        end
        for (int m = 0; m < 4; m++) begin
            mxfer(8'h71 | 8'(m << 2), 8'h1e, 8'hb4);
        end
        $display("master test done");
    endtask

    task automatic t_coll_over();
        clock_polarity <= 1'b0;
        clock_phase <= 1'b0;
        lsb <= 1'b0;
        sck_t <= 1'b0;
        far_tx <= 8'h11;
        wb(1'b1, 8'h00, 8'hd1);
        far_en <= 1'b1;
        wb(1'b1, 8'h08, 8'h22);
        wt(20);
        wb(1'b1, 8'h08, 8'h33);
        wait_done();
        chk(far_rx, 8'h22, "far rx");
        rd(8'h04, 8'hc0, "status");
        far_en <= 1'b0;
        far_tx <= 8'h44;
        wt(1);
        far_en <= 1'b1;
        wb(1'b1, 8'h08, 8'h55);
        wait_done();
        chk(far_rx, 8'h55, "far rx");
        rd(8'h04, 8'he0, "status");
        rd(8'h08, 8'h11, "data");
        wb(1'b1, 8'h04, 8'he0);
        rd(8'h04, 8'h00, "status");
        far_en <= 1'b0;
        $display("collision test done");
    endtask

    task automatic t_fault();
        ss_t <= 1'b0;
        wb(1'b1, 8'h00, 8'hd0);
        wt(10);
        rd(8'h04, 8'h00, "status");
        chk(irq, 1'b0, "irq");
        wb(1'b1, 8'h00, 8'h50);
        wt(10);
        rd(8'h04, 8'h10, "status");
        rd(8'h00, 8'h00, "control");
        chk(irq, 1'b1, "irq");
        ss_t <= 1'b1;
        wb(1'b1, 8'h04, 8'h10);
        rd(8'h04, 8'h00, "status");
        $display("fault test done");
    endtask

    task automatic t_slave();
        logic [7:0] r;
        wb(1'b1, 8'h00, 8'h40);
        wt(8);
        chk(miso_oe, 1'b0, "slave out off");
        fm_byte(8'h96, r);
        chk(r, 8'h00, "slave idle byte");
        rd(8'h04, 8'h80, "status");
        rd(8'h08, 8'h96, "data");
        wb(1'b1, 8'h04, 8'h80);
        wb(1'b1, 8'h08, 8'h6b);
        fm_byte(8'h0f, r);
        chk(r, 8'h6b, "slave byte");
        rd(8'h08, 8'h0f, "data");
        wb(1'b1, 8'h00, 8'h00);
        wt(4);
        chk({sck_oe, mosi_oe, miso_oe}, 8'h00, "pins off");
        $display("slave test done");
    endtask

    initial begin
        wt(3);
        rst_i <= 1'b0;
        t_reset();
        t_master();
        t_coll_over();
        t_fault();
        t_slave();
        print_verdict();
    end
endmodule
`default_nettype wire
